//--- common/obt_pkg.sv
// shared constants and types for the octal registered bus transceiver
package obt_pkg;

  // data path
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W = 2 * DATA_W + 2;

  // register byte offsets
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_CAPTURE = 32'h0000_0008;
  localparam logic [31:0] OFS_CLEAR = 32'h0000_000c;

  // control register: field order in the struct gives bit 0 first from the bottom
  localparam int unsigned CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h2;

  // status register field positions
  localparam int unsigned STAT_A_REG_LSB = 0;
  localparam int unsigned STAT_B_REG_LSB = 8;
  localparam int unsigned STAT_NONEMPTY_BIT = 16;
  localparam int unsigned STAT_OVF_BIT = 17;
  localparam int unsigned STAT_FULL_BIT = 18;

  // capture register and clear register field positions
  localparam int unsigned CAPT_VALID_BIT = 31;
  localparam int unsigned CLR_OVF_BIT = 0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ba_sel;
    logic ab_sel;
    logic ba_en_n;
    logic ab_en;
  } obt_ctrl_t;

  typedef struct packed {
    logic b_hit;
    logic a_hit;
    logic [DATA_W-1:0] b_data;
    logic [DATA_W-1:0] a_data;
  } obt_capt_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } obt_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } obt_axil_rsp_t;

endpackage

//--- rtl/obt_transceiver.sv
// octal registered bus transceiver with axi4-lite control and capture fifo
`timescale 1ns/10ps

module obt_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

module obt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != FULL);
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// Function
// - two 8-bit two-way ports A and B, one storage register per direction.
// - rising A-register clock stores A port; B clock stores B port; controls ignored.
// - select low passes live port data across, select high passes stored data.
// - A-to-B enable high, select low: B driven with live A; A stays input while B-to-A enable is high.
// - A-to-B enable high, select high: B driven from the A register.
// - B-to-A enable low, select low: A driven with live B; B stays input while A-to-B enable is low.
// - B-to-A enable low, select high: A driven from the B register.
// - both directions enabled, both selects high: both ports show opposite registers.
// - A-to-B enable low and B-to-A enable high: both ports undriven, capture continues.
// - every rising register clock stores port data, even with outputs disabled.
// - both enables high, select low: both clocks load the A value everywhere.
// - both enables low, select low: both clocks load the B value everywhere.
// - both directions live: each port drives the other, so buses keep state.
// - switching between live and stored data makes no output glitch.
module obt_transceiver
  import obt_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // register bus
  input wire obt_axil_req_t AXI_REQ_I,
  output obt_axil_rsp_t AXI_RSP_O,
  // a port pins
  input wire logic [DATA_W-1:0] A_PORT_I,
  output logic [DATA_W-1:0] A_PORT_O,
  output logic A_PORT_OE_O,
  // b port pins
  input wire logic [DATA_W-1:0] B_PORT_I,
  output logic [DATA_W-1:0] B_PORT_O,
  output logic B_PORT_OE_O,
  // register clock pins
  input wire logic A_REG_CLK_I,
  input wire logic B_REG_CLK_I,
  // capture flow
  output logic CAPTURE_READY_O
);

  // pin synchronisers: data and clocks share latency so they stay aligned
  logic [DATA_W-1:0] a_in_s;
  logic [DATA_W-1:0] b_in_s;
  logic [1:0] clk_s;
  logic [1:0] clk_d_q;

  obt_sync #(.W(DATA_W)) u_sync_a (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(A_PORT_I),
    .q_o(a_in_s)
  );

  obt_sync #(.W(DATA_W)) u_sync_b (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(B_PORT_I),
    .q_o(b_in_s)
  );

  obt_sync #(.W(2)) u_sync_clk (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i({B_REG_CLK_I, A_REG_CLK_I}),
    .q_o(clk_s)
  );

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      clk_d_q <= '0;
    end else begin
      clk_d_q <= clk_s;
    end
  end

  wire a_clk_edge = clk_s[0] && !clk_d_q[0];
  wire b_clk_edge = clk_s[1] && !clk_d_q[1];

  // storage registers
  logic [DATA_W-1:0] a_reg_q;
  logic [DATA_W-1:0] b_reg_q;

  // capture ignores enables and selects; with a port driven across,
  // the pin already carries the other side's data
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      a_reg_q <= '0;
      b_reg_q <= '0;
    end else begin
      if (a_clk_edge) begin
        a_reg_q <= a_in_s;
      end
      if (b_clk_edge) begin
        b_reg_q <= b_in_s;
      end
    end
  end

  // control register and output path
  obt_ctrl_t ctrl_q;
  logic [DATA_W-1:0] a_out_q;
  logic [DATA_W-1:0] b_out_q;

  wire [DATA_W-1:0] b_out_d = ctrl_q.ab_sel ? a_reg_q : a_in_s;
  wire [DATA_W-1:0] a_out_d = ctrl_q.ba_sel ? b_reg_q : b_in_s;

  // outputs leave a flop, so a select change swaps sources cleanly at one edge
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      a_out_q <= '0;
      b_out_q <= '0;
    end else begin
      b_out_q <= b_out_d;
      a_out_q <= a_out_d;
    end
  end

  assign B_PORT_O = b_out_q;
  assign A_PORT_O = a_out_q;
  assign B_PORT_OE_O = ctrl_q.ab_en;
  assign A_PORT_OE_O = !ctrl_q.ba_en_n;

  // capture fifo: one word per cycle holds both sides' edges
  obt_capt_t capt_in;
  obt_capt_t capt_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic ovf_q;

  assign capt_in.a_hit = a_clk_edge;
  assign capt_in.b_hit = b_clk_edge;
  assign capt_in.a_data = a_in_s;
  assign capt_in.b_data = b_in_s;
  wire capt_valid = a_clk_edge || b_clk_edge;

  obt_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .in_valid_i(capt_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(capt_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(capt_out)
  );

  // the pins cannot be stalled, so the outside is told to hold its clocks
  assign CAPTURE_READY_O = fifo_in_ready;

  // axi4-lite write side
  logic aw_held_q;
  logic w_held_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  wire awready = !aw_held_q && !bvalid_q;
  wire wready = !w_held_q && !bvalid_q;
  wire aw_hs = AXI_REQ_I.awvalid && awready;
  wire w_hs = AXI_REQ_I.wvalid && wready;
  wire wr_fire = (aw_hs || aw_held_q) && (w_hs || w_held_q);
  wire [31:0] wr_addr = aw_held_q ? awaddr_q : AXI_REQ_I.awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : AXI_REQ_I.wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : AXI_REQ_I.wstrb;
  wire wr_ctrl = wr_fire && (wr_addr == OFS_CTRL) && wr_strb[0];
  wire wr_clear = wr_fire && (wr_addr == OFS_CLEAR) && wr_strb[0];
  wire wr_ok = (wr_addr == OFS_CTRL) || (wr_addr == OFS_CLEAR);
  wire ovf_clr = wr_clear && wr_data[CLR_OVF_BIT];
  wire ovf_set = capt_valid && !fifo_in_ready;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_q <= AXI_REQ_I.awaddr;
      end
      if (w_hs) begin
        wdata_q <= AXI_REQ_I.wdata;
        wstrb_q <= AXI_REQ_I.wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else begin
        aw_held_q <= aw_held_q || aw_hs;
        w_held_q <= w_held_q || w_hs;
        if (AXI_REQ_I.bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  // control and sticky overflow; a new drop wins over a clear in the same cycle
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_q <= obt_ctrl_t'(CTRL_RESET);
      ovf_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= obt_ctrl_t'(wr_data[CTRL_W-1:0]);
      end
      ovf_q <= ovf_set || (ovf_q && !ovf_clr);
    end
  end

  // axi4-lite read side; reading capture pops one word
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] status_word;
  logic [31:0] capt_word;

  wire arready = !rvalid_q;
  wire ar_hs = AXI_REQ_I.arvalid && arready;
  wire rd_ctrl = (AXI_REQ_I.araddr == OFS_CTRL);
  wire rd_status = (AXI_REQ_I.araddr == OFS_STATUS);
  wire rd_capt = (AXI_REQ_I.araddr == OFS_CAPTURE);
  wire rd_ok = rd_ctrl || rd_status || rd_capt;
  assign fifo_pop = ar_hs && rd_capt;

  always_comb begin
    status_word = '0;
    status_word[STAT_A_REG_LSB +: DATA_W] = a_reg_q;
    status_word[STAT_B_REG_LSB +: DATA_W] = b_reg_q;
    status_word[STAT_NONEMPTY_BIT] = fifo_out_valid;
    status_word[STAT_OVF_BIT] = ovf_q;
    status_word[STAT_FULL_BIT] = !fifo_in_ready;
    capt_word = '0;
    capt_word[FIFO_W-1:0] = fifo_out_valid ? capt_out : '0;
    capt_word[CAPT_VALID_BIT] = fifo_out_valid;
  end

  wire [31:0] rd_mux = rd_ctrl ? {{(32 - CTRL_W){1'b0}}, ctrl_q} :
                       rd_status ? status_word :
                       rd_capt ? capt_word : '0;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (AXI_REQ_I.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign AXI_RSP_O.awready = awready;
  assign AXI_RSP_O.wready = wready;
  assign AXI_RSP_O.bvalid = bvalid_q;
  assign AXI_RSP_O.bresp = bresp_q;
  assign AXI_RSP_O.arready = arready;
  assign AXI_RSP_O.rvalid = rvalid_q;
  assign AXI_RSP_O.rdata = rdata_q;
  assign AXI_RSP_O.rresp = rresp_q;

  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_a_edge;
    a_clk_edge;
  endsequence

  sequence s_b_edge;
    b_clk_edge;
  endsequence

  a_capture_a_reg: assert property (s_a_edge |=> a_reg_q == $past(a_in_s))
    else $error("a register missed its capture");
  a_capture_b_reg: assert property (s_b_edge |=> b_reg_q == $past(b_in_s))
    else $error("b register missed its capture");
  a_hold_a_reg: assert property (!a_clk_edge |=> $stable(a_reg_q))
    else $error("a register changed without an edge");
  a_hold_b_reg: assert property (!b_clk_edge |=> $stable(b_reg_q))
    else $error("b register changed without an edge");
  a_b_live_drive: assert property (B_PORT_OE_O && !ctrl_q.ab_sel |=> B_PORT_O == $past(a_in_s))
    else $error("b port not showing live a data");
  a_b_stored_drive: assert property (B_PORT_OE_O && ctrl_q.ab_sel |=> B_PORT_O == $past(a_reg_q))
    else $error("b port not showing the a register");
  a_a_live_drive: assert property (A_PORT_OE_O && !ctrl_q.ba_sel |=> A_PORT_O == $past(b_in_s))
    else $error("a port not showing live b data");
  a_a_stored_drive: assert property (A_PORT_OE_O && ctrl_q.ba_sel |=> A_PORT_O == $past(b_reg_q))
    else $error("a port not showing the b register");
  a_both_ports_drive: assert property (ctrl_q.ab_en && !ctrl_q.ba_en_n |-> A_PORT_OE_O && B_PORT_OE_O)
    else $error("both directions enabled but a port is released");
  a_isolation_mode: assert property (!ctrl_q.ab_en && ctrl_q.ba_en_n |-> !A_PORT_OE_O && !B_PORT_OE_O)
    else $error("isolation but a port is driven");
  a_sel_switch_clean: assert property ($changed(ctrl_q.ab_sel) |->
    B_PORT_O == $past(a_in_s) || B_PORT_O == $past(a_reg_q))
    else $error("b output blended sources in the select change cycle");
  a_ovf_sticky: assert property (ovf_set |=> ovf_q)
    else $error("dropped capture not flagged");

endmodule

//--- testbench/obt_bus_model.sv
// model of the outside logic on both data buses and the register clock pins
`timescale 1ns/10ps

module obt_bus_model
  import obt_pkg::*;
(
  // clock
  input wire logic clk_i,
  // device drivers
  input wire logic [DATA_W-1:0] a_dev_i,
  input wire logic a_oe_i,
  input wire logic [DATA_W-1:0] b_dev_i,
  input wire logic b_oe_i,
  // resolved bus levels
  output logic [DATA_W-1:0] a_bus_o,
  output logic [DATA_W-1:0] b_bus_o,
  // register clock pins
  output logic a_clk_o,
  output logic b_clk_o
);
  logic a_en_q = 1'b0;
  logic b_en_q = 1'b0;
  logic [DATA_W-1:0] a_drv_q = '0;
  logic [DATA_W-1:0] b_drv_q = '0;
  logic [DATA_W-1:0] a_hold_q = '0;
  logic [DATA_W-1:0] b_hold_q = '0;

  // the device wins a clash; with nobody driving, bus hold keeps the last level
  assign a_bus_o = a_oe_i ? a_dev_i : (a_en_q ? a_drv_q : a_hold_q);
  assign b_bus_o = b_oe_i ? b_dev_i : (b_en_q ? b_drv_q : b_hold_q);

  always @(posedge clk_i) begin
    a_hold_q <= a_bus_o;
    b_hold_q <= b_bus_o;
  end

  initial begin
    a_clk_o = 1'b0;
    b_clk_o = 1'b0;
  end

  task automatic drive_a(input logic en, input logic [DATA_W-1:0] v);
    a_en_q <= en;
    a_drv_q <= v;
  endtask

  task automatic drive_b(input logic en, input logic [DATA_W-1:0] v);
    b_en_q <= en;
    b_drv_q <= v;
  endtask

  // 3 cycles high and low keeps clear of the 1-cycle minimum seen by the synchronisers
  task automatic pulse(input logic on_a, input logic on_b);
    repeat (4) @(posedge clk_i);
    a_clk_o <= on_a;
    b_clk_o <= on_b;
    repeat (3) @(posedge clk_i);
    a_clk_o <= 1'b0;
    b_clk_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking testbench for the octal registered bus transceiver
`timescale 1ns/10ps

module testbench;
  import obt_pkg::*;
  localparam int CYCLE_LIMIT = 20000;
  logic clk = 1'b0;
  logic rst;
  obt_axil_req_t axi_req;
  obt_axil_rsp_t axi_rsp;
  logic [DATA_W-1:0] a_o, b_o, a_bus, b_bus;
  logic a_oe, b_oe, a_clk, b_clk, capt_ready;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  obt_transceiver u_obt_transceiver (.CLK_I(clk), .RST_I(rst), .AXI_REQ_I(axi_req), .AXI_RSP_O(axi_rsp),
    .A_PORT_I(a_bus), .A_PORT_O(a_o), .A_PORT_OE_O(a_oe), .B_PORT_I(b_bus), .B_PORT_O(b_o),
    .B_PORT_OE_O(b_oe), .A_REG_CLK_I(a_clk), .B_REG_CLK_I(b_clk), .CAPTURE_READY_O(capt_ready));

  obt_bus_model u_obt_bus_model (.clk_i(clk), .a_dev_i(a_o), .a_oe_i(a_oe), .b_dev_i(b_o), .b_oe_i(b_oe),
    .a_bus_o(a_bus), .b_bus_o(b_bus), .a_clk_o(a_clk), .b_clk_o(b_clk));

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // handshakes are judged at the falling edge, where the levels taken at the next rising edge are settled
  task automatic reg_wr(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] exp_resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    axi_req.awaddr <= addr;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata <= data;
    axi_req.wstrb <= 4'hf;
    axi_req.wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk);
      if (axi_req.awvalid && axi_rsp.awready === 1'b1) aw_ok = 1'b1;
      if (axi_req.wvalid && axi_rsp.wready === 1'b1) w_ok = 1'b1;
      @(posedge clk);
      if (aw_ok) axi_req.awvalid <= 1'b0;
      if (w_ok) axi_req.wvalid <= 1'b0;
    end
    do @(negedge clk); while (axi_rsp.bvalid !== 1'b1);
    check("bresp", {30'h0, exp_resp}, {30'h0, axi_rsp.bresp});
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [31:0] addr, input logic [31:0] mask, input logic [31:0] exp,
                        input logic [1:0] exp_resp);
    axi_req.araddr <= addr;
    axi_req.arvalid <= 1'b1;
    do @(negedge clk); while (axi_rsp.arready !== 1'b1);
    @(posedge clk);
    axi_req.arvalid <= 1'b0;
    do @(negedge clk); while (axi_rsp.rvalid !== 1'b1);
    check("rresp", {30'h0, exp_resp}, {30'h0, axi_rsp.rresp});
    check("rdata", exp & mask, axi_rsp.rdata & mask);
    @(posedge clk);
  endtask

  // ctrl bits: [0] a-to-b enable, [1] b-to-a enable low-active, [2] a-to-b select, [3] b-to-a select
  task automatic set_ctrl(input logic [3:0] c);
    reg_wr(OFS_CTRL, {28'h0, c}, RESP_OKAY);
  endtask

  // waits out the synchroniser and output register latency, then looks at the resolved buses
  task automatic pins(input logic [7:0] ea, input logic [7:0] eb, input logic [1:0] eoe);
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("a bus", {24'h0, ea}, {24'h0, a_bus});
    check("b bus", {24'h0, eb}, {24'h0, b_bus});
    check("a/b enables", {30'h0, eoe}, {30'h0, a_oe, b_oe});
    @(posedge clk);
  endtask

  task automatic regs(input logic [7:0] ea, input logic [7:0] eb);
    reg_rd(OFS_STATUS, 32'h0000_ffff, {16'h0, eb, ea}, RESP_OKAY);
  endtask

  task automatic pop(input logic ah, input logic bh, input logic [7:0] ea, input logic [7:0] eb);
    reg_rd(OFS_CAPTURE, 32'h8003_0000 | {16'h0, {8{bh}}, {8{ah}}}, {1'b1, 13'h0, bh, ah, eb, ea}, RESP_OKAY);
  endtask

  task automatic t_reset_map();
    reg_rd(OFS_CTRL, 32'hffff_ffff, {28'h0, CTRL_RESET}, RESP_OKAY);
    pins(8'h00, 8'h00, 2'b00);
    reg_rd(32'h0000_0010, 32'hffff_ffff, 32'h0, RESP_SLVERR);
    reg_wr(OFS_STATUS, 32'hffff_ffff, RESP_SLVERR);
  endtask

  task automatic t_isolation_store();
    u_obt_bus_model.drive_a(1'b1, 8'h5a);
    u_obt_bus_model.drive_b(1'b1, 8'hc3);
    u_obt_bus_model.pulse(1'b1, 1'b1);
    pins(8'h5a, 8'hc3, 2'b00);
    regs(8'h5a, 8'hc3);
    pop(1'b1, 1'b1, 8'h5a, 8'hc3);
  endtask

  task automatic t_a_to_b();
    u_obt_bus_model.drive_b(1'b0, 8'h00);
    u_obt_bus_model.drive_a(1'b1, 8'h3c);
    set_ctrl(4'h3);
    pins(8'h3c, 8'h3c, 2'b01);
    u_obt_bus_model.drive_a(1'b1, 8'h96);
    pins(8'h96, 8'h96, 2'b01);
    set_ctrl(4'h7);
    pins(8'h96, 8'h5a, 2'b01);
    u_obt_bus_model.drive_a(1'b1, 8'h11);
    pins(8'h11, 8'h5a, 2'b01);
    regs(8'h5a, 8'hc3);
  endtask

  task automatic t_b_to_a();
    set_ctrl(4'h2);
    u_obt_bus_model.drive_a(1'b0, 8'h00);
    u_obt_bus_model.drive_b(1'b1, 8'h81);
    set_ctrl(4'h0);
    pins(8'h81, 8'h81, 2'b10);
    set_ctrl(4'h8);
    pins(8'hc3, 8'h81, 2'b10);
    u_obt_bus_model.drive_b(1'b0, 8'h00);
    set_ctrl(4'hd);
    pins(8'hc3, 8'h5a, 2'b11);
  endtask

  task automatic t_double_load();
    set_ctrl(4'h2);
    u_obt_bus_model.drive_a(1'b1, 8'h4e);
    set_ctrl(4'h3);
    pins(8'h4e, 8'h4e, 2'b01);
    u_obt_bus_model.pulse(1'b1, 1'b1);
    regs(8'h4e, 8'h4e);
    pop(1'b1, 1'b1, 8'h4e, 8'h4e);
    // live and stored data now match, so the b bus must not move while the select flips
    set_ctrl(4'h7);
    repeat (12) begin
      @(negedge clk);
      check("b bus steady", 32'h4e, {24'h0, b_bus});
    end
    @(posedge clk);
    set_ctrl(4'h2);
    u_obt_bus_model.drive_a(1'b0, 8'h00);
    u_obt_bus_model.drive_b(1'b1, 8'ha7);
    set_ctrl(4'h0);
    pins(8'ha7, 8'ha7, 2'b10);
    u_obt_bus_model.pulse(1'b1, 1'b1);
    regs(8'ha7, 8'ha7);
    pop(1'b1, 1'b1, 8'ha7, 8'ha7);
  endtask

  task automatic t_loop_hold();
    set_ctrl(4'h2);
    u_obt_bus_model.drive_b(1'b0, 8'h00);
    u_obt_bus_model.drive_a(1'b1, 8'h33);
    set_ctrl(4'h3);
    pins(8'h33, 8'h33, 2'b01);
    set_ctrl(4'h1);
    u_obt_bus_model.drive_a(1'b0, 8'h00);
    pins(8'h33, 8'h33, 2'b11);
    repeat (20) @(posedge clk);
    pins(8'h33, 8'h33, 2'b11);
  endtask

  task automatic t_fifo();
    set_ctrl(4'h2);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      u_obt_bus_model.drive_a(1'b1, 8'h20 + i[7:0]);
      u_obt_bus_model.pulse(1'b1, 1'b0);
    end
    check("capture ready", 32'h0, {31'h0, capt_ready});
    reg_rd(OFS_STATUS, 32'h0007_0000, 32'h0005_0000, RESP_OKAY);
    // one clock too many: the word is dropped but the register still stores
    u_obt_bus_model.drive_a(1'b1, 8'h30);
    u_obt_bus_model.pulse(1'b1, 1'b0);
    reg_rd(OFS_STATUS, 32'h0007_00ff, 32'h0007_0030, RESP_OKAY);
    reg_wr(OFS_CLEAR, 32'h1, RESP_OKAY);
    reg_rd(OFS_STATUS, 32'h0002_0000, 32'h0, RESP_OKAY);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      pop(1'b1, 1'b0, 8'h20 + i[7:0], 8'h00);
    end
    reg_rd(OFS_CAPTURE, 32'h8000_0000, 32'h0, RESP_OKAY);
    reg_rd(OFS_STATUS, 32'h0005_0000, 32'h0, RESP_OKAY);
    check("capture ready", 32'h1, {31'h0, capt_ready});
  endtask

  initial begin
    rst <= 1'b1;
    axi_req <= '{bready: 1'b1, rready: 1'b1, default: '0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_map();
    t_isolation_store();
    t_a_to_b();
    t_b_to_a();
    t_double_load();
    t_loop_hold();
    t_fifo();
    report_and_stop();
  end
endmodule
